// file: verilog/uil_regs.vh
// Purpose: Register offsets, field positions, codes and reset values of the UART interrupt logic.
// Assumes: Included once by the interrupt logic module.
// Notes:   Offsets are indices on the plain register port.
`ifndef UIL_REGS_VH
`define UIL_REGS_VH

`define UIL_ADDR_W        3
`define UIL_OFF_ENABLE    3'h1
`define UIL_OFF_STATUS    3'h2
`define UIL_OFF_LINE      3'h5
`define UIL_OFF_MODEM     3'h6

`define UIL_EN_RX         0
`define UIL_EN_TX         1
`define UIL_EN_LINE       2
`define UIL_EN_MODEM      3
`define UIL_EN_SLEEP      4
`define UIL_EN_XOFF       5
`define UIL_EN_RTS        6
`define UIL_EN_CTS        7

`define UIL_ENABLE_RESET  8'h00
`define UIL_ENABLE_LOCK   8'h0F

`define UIL_CODE_LINE     6'h06
`define UIL_CODE_TIMEOUT  6'h0C
`define UIL_CODE_RX       6'h04
`define UIL_CODE_TX       6'h02
`define UIL_CODE_MODEM    6'h00
`define UIL_CODE_XOFF     6'h10
`define UIL_CODE_FLOW     6'h20
`define UIL_CODE_NONE     6'h01

`define UIL_FIFO_ON       2'h3
`define UIL_FIFO_OFF      2'h0

`define UIL_LINE_RESET    8'h60
`define UIL_RDATA_IDLE    8'h00
`define UIL_TX_SRC_IDLE   1'b1

`endif

// file: verilog/uil_interrupt_logic.v
// Purpose: Interrupt enable, pending, priority encode and clear logic of one UART channel.
// Assumes: All event inputs come from logic on the same clock; reads and writes use a
//          plain strobed register port with read data one cycle later.
// Notes:   Line status is built here but read out elsewhere; modem status lives elsewhere; their read strobes clear here.
`timescale 1ns/10ps
`include "uil_regs.vh"

// Function
// - FIFO mode receive interrupt follows trigger level reached, clears below it.
// - Data-ready flag sets on character into FIFO, clears when FIFO empty.
// - FIFO enabled with enable bits 0-3 clear gives polled mode.
// - Line status bits: overrun, error type, holding empty, all empty, fifo error.
// - Non-FIFO receive interrupt while holding register full; enable resets off.
// - Transmit ready on empty or below trigger, and at once if enabled while empty.
// - Overrun interrupts at once; other errors on readout or at once if chosen.
// - Modem status interrupt when any modem change bit 0-3 is set.
// - Enable bits 4-7 writable only with enhanced enable; reset to zero.
// - Xoff or special character match sets status bit 4 and interrupts.
// - Interrupt on auto RTS output rise and auto CTS input rise.
// - Status bit 5 reports flow change, active only with enable 6 or 7.
// - Status read gives highest pending code; lower sources stay pending, except Xoff and special, which any status read clears.
// - Codes by priority: 06, 0C, 04, 02, 00, 10, 20; none is 01.
// - Status bit 0 low while pending, high when none, high at reset.
// - Status bits 7 and 6 both follow FIFO enable.
// - Receive timeout raised by delay timer, cleared by holding register read.
// - Transmit source uses trigger or empty, or fully empty in RS-485 mode.
// - Line read, data below trigger, status read or write, modem read clear sources.
// - Xoff clears on status read or Xon; special on status read or next char.
// - Flow change interrupts clear only on modem status register read.
module uil_interrupt_logic (
  input  wire                   clock,
  input  wire                   rst_n,
  input  wire [`UIL_ADDR_W-1:0] regAddr,
  input  wire [7:0]             regWrData,
  input  wire                   regWrStb,
  input  wire                   regRdStb,
  output reg  [7:0]             regRdData,
  input  wire                   fifoEnable,
  input  wire                   enhancedEnable,
  input  wire                   errImmediate,
  input  wire                   rs485Mode,
  input  wire                   rxFifoLoad,
  input  wire                   rxEmpty,
  input  wire                   rxTrigReached,
  input  wire                   rxTimeout,
  input  wire                   rxHoldRead,
  input  wire                   rxOverrun,
  input  wire [2:0]             headErrors,
  input  wire                   headPop,
  input  wire                   fifoHasError,
  input  wire                   txHoldEmpty,
  input  wire                   txBelowTrig,
  input  wire                   txAllEmpty,
  input  wire                   txHoldWrite,
  input  wire [3:0]             modemChange,
  input  wire                   xoffMatch,
  input  wire                   xonMatch,
  input  wire                   specialMatch,
  input  wire                   rxCharDone,
  input  wire                   autoRtsOn,
  input  wire                   autoCtsOn,
  input  wire                   rtsRise,
  input  wire                   ctsRise,
  output reg                    irqOut,
  output reg  [7:0]             lineStatus,
  output reg                    pollMode,
  output reg                    sleepMode
);

  reg  [7:0] enable_q;
  reg        lineIrq_q;
  reg        overrun_q;
  reg        timeout_q;
  reg        txIrq_q;
  reg        txSrcDly_q;
  reg        xoffIrq_q;
  reg        specIrq_q;
  reg        flowIrq_q;
  reg        dataReady_q;
  reg  [7:0] isrView;
  wire       statusRead;
  wire       lineRead;
  wire       modemRead;
  wire       enableWrite;
  wire       txSource;
  wire       rxSource;
  wire       lineEvent;
  wire [5:0] code;
  wire [7:0] enableNext;

  // Encoding in strict priority order, one code at a time.
  function [5:0] prioCode;
    input [6:0] pend;
    begin
      if (pend[0])
        prioCode = `UIL_CODE_LINE;
      else if (pend[1])
        prioCode = `UIL_CODE_TIMEOUT;
      else if (pend[2])
        prioCode = `UIL_CODE_RX;
      else if (pend[3])
        prioCode = `UIL_CODE_TX;
      else if (pend[4])
        prioCode = `UIL_CODE_MODEM;
      else if (pend[5])
        prioCode = `UIL_CODE_XOFF;
      else if (pend[6])
        prioCode = `UIL_CODE_FLOW;
      else
        prioCode = `UIL_CODE_NONE;
    end
  endfunction

  assign statusRead  = regRdStb && (regAddr == `UIL_OFF_STATUS);
  assign lineRead    = regRdStb && (regAddr == `UIL_OFF_LINE);
  assign modemRead   = regRdStb && (regAddr == `UIL_OFF_MODEM);
  assign enableWrite = regWrStb && (regAddr == `UIL_OFF_ENABLE);

  assign enableNext = enhancedEnable ? regWrData :
                      ((regWrData & `UIL_ENABLE_LOCK) | (enable_q & ~`UIL_ENABLE_LOCK));

  assign rxSource = fifoEnable ? rxTrigReached : !rxEmpty;

  assign txSource = rs485Mode ? txAllEmpty : (fifoEnable ? txBelowTrig : txHoldEmpty);

  assign lineEvent = rxOverrun || (|headErrors && (errImmediate ? rxFifoLoad : headPop));

  assign code = prioCode({
    flowIrq_q && (enable_q[`UIL_EN_RTS] || enable_q[`UIL_EN_CTS]),
    (xoffIrq_q || specIrq_q) && enable_q[`UIL_EN_XOFF],
    (|modemChange) && enable_q[`UIL_EN_MODEM],
    txIrq_q && enable_q[`UIL_EN_TX],
    rxSource && enable_q[`UIL_EN_RX],
    timeout_q && enable_q[`UIL_EN_RX],
    lineIrq_q && enable_q[`UIL_EN_LINE]});

  always @* begin
    isrView = {(fifoEnable ? `UIL_FIFO_ON : `UIL_FIFO_OFF), code};
  end

  // Set and clear terms are named once, so each flag below stays a plain set-wins flop.
  wire       txRise;
  wire       txEnableRise;
  wire       txClear;
  wire       flowEvent;
  wire       xoffClear;
  wire       specialClear;

  assign txRise       = txSource && !txSrcDly_q;
  assign txEnableRise = enableWrite && enableNext[`UIL_EN_TX] && !enable_q[`UIL_EN_TX] &&
                        txSource;

  // Status read or write
  // Only a read that reports the transmit code clears it, so a status read taken while a
  // higher source is pending does not lose the transmit request.
  assign txClear = (statusRead && (code == `UIL_CODE_TX)) || txHoldWrite;

  assign flowEvent = (rtsRise && autoRtsOn && enable_q[`UIL_EN_RTS]) ||
                     (ctsRise && autoCtsOn && enable_q[`UIL_EN_CTS]);

  assign xoffClear    = statusRead || xonMatch;
  assign specialClear = statusRead || rxCharDone;

  always @(posedge clock) begin
    if (!rst_n) begin
      enable_q <= `UIL_ENABLE_RESET;
    end else if (enableWrite) begin
      enable_q <= enableNext;
    end
  end

  // Sleep lags the enable bit by one cycle; the clock gating that uses it lives elsewhere.
  always @(posedge clock) begin
    if (!rst_n) begin
      sleepMode <= 1'b0;
    end else begin
      sleepMode <= enable_q[`UIL_EN_SLEEP];
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      lineIrq_q <= 1'b0;
    end else if (lineEvent) begin
      lineIrq_q <= 1'b1;
    end else if (lineRead) begin
      lineIrq_q <= 1'b0;
    end
  end

  // Overrun is held for the line status view until the line status read.
  always @(posedge clock) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else if (rxOverrun) begin
      overrun_q <= 1'b1;
    end else if (lineRead) begin
      overrun_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      timeout_q <= 1'b0;
    end else if (rxTimeout) begin
      timeout_q <= 1'b1;
    end else if (rxHoldRead) begin
      timeout_q <= 1'b0;
    end
  end

  // Resets to the level of an empty holding register, so no false edge follows reset.
  always @(posedge clock) begin
    if (!rst_n) begin
      txSrcDly_q <= `UIL_TX_SRC_IDLE;
    end else begin
      txSrcDly_q <= txSource;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      txIrq_q <= 1'b0;
    end else if (txRise || txEnableRise) begin
      txIrq_q <= 1'b1;
    end else if (txClear) begin
      txIrq_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      xoffIrq_q <= 1'b0;
    end else if (xoffMatch) begin
      xoffIrq_q <= 1'b1;
    end else if (xoffClear) begin
      xoffIrq_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      specIrq_q <= 1'b0;
    end else if (specialMatch) begin
      specIrq_q <= 1'b1;
    end else if (specialClear) begin
      specIrq_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      flowIrq_q <= 1'b0;
    end else if (flowEvent) begin
      flowIrq_q <= 1'b1;
    end else if (modemRead) begin
      flowIrq_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      dataReady_q <= 1'b0;
    end else if (rxFifoLoad) begin
      dataReady_q <= 1'b1;
    end else if (rxEmpty) begin
      dataReady_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      lineStatus <= `UIL_LINE_RESET;
    end else begin
      lineStatus <= {fifoHasError, txAllEmpty, txHoldEmpty, headErrors,
                     overrun_q, dataReady_q};
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      pollMode <= 1'b0;
    end else begin
      pollMode <= fifoEnable && (enable_q[`UIL_EN_MODEM:`UIL_EN_RX] == 4'h0);
    end
  end

  // Pending indicator
  // Registered so the pin cannot glitch while the priority encoder settles.
  always @(posedge clock) begin
    if (!rst_n) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= (code != `UIL_CODE_NONE);
    end
  end

  // Read data stand for one cycle only and then fall back to the idle value, so a
  // sample taken outside that cycle never shows a stale register.
  always @(posedge clock) begin
    if (!rst_n) begin
      regRdData <= `UIL_RDATA_IDLE;
    end else if (regRdStb) begin
      case (regAddr)
        `UIL_OFF_ENABLE: begin
          regRdData <= enable_q;
        end
        `UIL_OFF_STATUS: begin
          regRdData <= isrView;
        end
        default: begin
          regRdData <= `UIL_RDATA_IDLE;
        end
      endcase
    end else begin
      regRdData <= `UIL_RDATA_IDLE;
    end
  end

endmodule // uil_interrupt_logic

// file: verification/uil_asserts.sv
// Purpose: Port assertions of the UART interrupt logic.
// Assumes: Only the top module ports are seen.
// Notes:   Bound at the foot of this file.
`timescale 1ns/10ps
module uil_asserts (
  input wire       clock,
  input wire       rst_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWrStb,
  input wire       regRdStb,
  input wire [7:0] regRdData,
  input wire       fifoEnable,
  input wire       enhancedEnable,
  input wire       rxFifoLoad,
  input wire       txHoldEmpty,
  input wire       txAllEmpty,
  input wire [7:0] lineStatus,
  input wire       pollMode,
  input wire       sleepMode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data not idle");
  fifo_bits_a: assert property ($past(regRdStb && regAddr == 3'h2)
    |-> regRdData[7:6] == {2{$past(fifoEnable)}}) else $error("fifo status bits wrong");
  code_legal_a: assert property ($past(regRdStb && regAddr == 3'h2) |-> regRdData[5:0]
    inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01}) else $error("bad code");
  sleep_write_a: assert property (regWrStb && regAddr == 3'h1 && enhancedEnable
    |=> ##1 sleepMode == $past(regWrData[4], 2)) else $error("sleep bit not written");
  sleep_lock_a: assert property (regWrStb && regAddr == 3'h1 && !enhancedEnable
    |=> ##1 $stable(sleepMode)) else $error("sleep bit written while locked");
  poll_mode_a: assert property (regWrStb && regAddr == 3'h1 && regWrData[3:0] == 4'h0
    && fifoEnable ##1 (fifoEnable && !regWrStb) ##1 fifoEnable |-> pollMode)
    else $error("poll mode missing");
  tx_flags_a: assert property ($past(rst_n) |-> lineStatus[6:5]
    == {$past(txAllEmpty), $past(txHoldEmpty)}) else $error("transmit flags wrong");
  ready_set_a: assert property (rxFifoLoad |-> ##2 lineStatus[0])
    else $error("data ready not set");
endmodule // uil_asserts

bind uil_interrupt_logic uil_asserts u_chk (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .fifoEnable(fifoEnable), .enhancedEnable(enhancedEnable), .rxFifoLoad(rxFifoLoad),
  .txHoldEmpty(txHoldEmpty), .txAllEmpty(txAllEmpty), .lineStatus(lineStatus),
  .pollMode(pollMode), .sleepMode(sleepMode));

// file: verification/uil_host_model.sv
// Purpose: Host processor model on the plain register port.
// Assumes: Read data stands only in the cycle after the strobe.
// Notes:   Idle write data is inverted so a stale byte is never mistaken for a fresh one.
`timescale 1ns/10ps
module uil_host_model (
  input  wire       clock,
  output reg  [2:0] regAddr = 3'h0,
  output reg  [7:0] regWrData = 8'h00,
  output reg        regWrStb = 1'b0,
  output reg        regRdStb = 1'b0,
  input  wire [7:0] regRdData
);
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clock);
      regWrStb <= 1'b0;
      regWrData <= ~d;
    end
  endtask
  task rd(input [2:0] a, output [7:0] d);
    begin
      @(posedge clock);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge clock);
      regRdStb <= 1'b0;
      #1 d = regRdData;
    end
  endtask
endmodule // uil_host_model

// file: verification/uil_interrupt_logic_tb_top.sv
// Purpose: Self-checking bench of the UART interrupt logic.
// Assumes: ev holds the event pulses in port order, lv the levels in port order except fifoHasError at bit 6.
// Notes:   mode holds the immediate-error, RS-485, auto RTS and auto CTS selects in that order.
`timescale 1ns/10ps
module uil_interrupt_logic_tb_top;
  reg        clock = 1'b0;
  reg        rst_n = 1'b0;
  reg [11:0] ev = 12'h000;
  reg [6:0]  lv = 7'h34;
  reg [3:0]  mode = 4'hC;
  reg [3:0]  modemChange = 4'h0;
  reg [2:0]  headErrors = 3'h0;
  reg [7:0]  rdv;
  integer    fail_count = 0;
  integer    cmp_count = 0;
  wire [2:0] regAddr;
  wire [7:0] regWrData, regRdData, lineStatus;
  wire       regWrStb, regRdStb, irqOut, pollMode, sleepMode;
  uil_host_model i_host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));
  uil_interrupt_logic i_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .fifoEnable(lv[0]), .enhancedEnable(lv[1]), .errImmediate(mode[0]), .rs485Mode(mode[1]),
    .rxFifoLoad(ev[0]), .rxEmpty(lv[2]), .rxTrigReached(lv[3]), .rxTimeout(ev[1]),
    .rxHoldRead(ev[2]), .rxOverrun(ev[3]), .headErrors(headErrors), .headPop(ev[4]),
    .fifoHasError(lv[6]), .txHoldEmpty(lv[4]), .txBelowTrig(1'b0), .txAllEmpty(lv[5]),
    .txHoldWrite(ev[5]), .modemChange(modemChange), .xoffMatch(ev[6]), .xonMatch(ev[7]),
    .specialMatch(ev[8]), .rxCharDone(ev[9]), .autoRtsOn(mode[2]), .autoCtsOn(mode[3]),
    .rtsRise(ev[10]), .ctsRise(ev[11]), .irqOut(irqOut), .lineStatus(lineStatus),
    .pollMode(pollMode), .sleepMode(sleepMode));
  initial begin
    forever #2.5 clock = ~clock;
  end
  task chk(input [63:0] n, input [7:0] e, input [7:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("Error %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task pulse(input integer i);
    begin
      @(posedge clock);
      ev[i] <= 1'b1;
      @(posedge clock);
      ev <= 12'h000;
    end
  endtask
  task st(input [7:0] e);
    begin
      i_host.rd(3'h2, rdv);
      chk("status", e, rdv);
    end
  endtask
  task t_enable;
    begin
      st(8'h01);
      chk("line", 8'h60, lineStatus);
      i_host.wr(3'h1, 8'hFF);
      i_host.rd(3'h1, rdv);
      chk("locked", 8'h0F, rdv);
      @(posedge clock) lv[1] <= 1'b1;
      i_host.wr(3'h1, 8'hFF);
      i_host.rd(3'h1, rdv);
      chk("open", 8'hFF, rdv);
      chk("sleep", 8'h01, {7'h00, sleepMode});
      $display("test enable done");
    end
  endtask
  task t_priority;
    begin
      @(posedge clock) lv[3] <= 1'b1;
      lv[0] <= 1'b1;
      modemChange <= 4'h1;
      pulse(3);
      pulse(1);
      pulse(11);
      pulse(10);
      st(8'hC6);
      chk("irq", 8'h01, {7'h00, irqOut});
      i_host.rd(3'h5, rdv);
      st(8'hCC);
      pulse(2);
      st(8'hC4);
      @(posedge clock) lv[3] <= 1'b0;
      st(8'hC2);
      st(8'hC0);
      @(posedge clock) modemChange <= 4'h0;
      pulse(6);
      st(8'hD0);
      st(8'hE0);
      i_host.rd(3'h6, rdv);
      st(8'hC1);
      chk("irq", 8'h00, {7'h00, irqOut});
      $display("test priority done");
    end
  endtask
  task t_plain;
    begin
      @(posedge clock) lv[0] <= 1'b0;
      lv[2] <= 1'b0;
      pulse(0);
      st(8'h04);
      @(posedge clock) lv <= 7'h46;
      @(posedge clock) lv <= 7'h36;
      st(8'h02);
      @(posedge clock) lv <= 7'h26;
      @(posedge clock) lv <= 7'h36;
      pulse(5);
      st(8'h01);
      @(posedge clock) headErrors <= 3'h2;
      pulse(4);
      st(8'h06);
      i_host.rd(3'h5, rdv);
      @(posedge clock) headErrors <= 3'h0;
      pulse(6);
      pulse(7);
      pulse(8);
      pulse(9);
      st(8'h01);
      @(posedge clock) lv[0] <= 1'b1;
      i_host.wr(3'h1, 8'hF0);
      repeat (2) @(posedge clock);
      #1 chk("poll", 8'h01, {7'h00, pollMode});
      $display("test plain done");
    end
  endtask
  task t_modes;
    begin
      i_host.wr(3'h1, 8'h06);
      @(posedge clock) headErrors <= 3'h4;
      mode[0] <= 1'b1;
      pulse(0);
      st(8'hC6);
      i_host.rd(3'h5, rdv);
      @(posedge clock) headErrors <= 3'h0;
      mode[1] <= 1'b1;
      st(8'hC2);
      $display("test modes done");
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_enable;
    t_priority;
    t_plain;
    t_modes;
    finish_test;
  end
  // A hung read would otherwise stall the run silently.
  initial begin
    #20000 fail_count = fail_count + 1;
    finish_test;
  end
endmodule // uil_interrupt_logic_tb_top
